// >>> logic/transfer_engine_regs.svh
// Register offsets, field positions, reset values and layout counts of the transfer engine
// Assumes a 16-bit register address, 8-bit register data and a 24-bit memory address
`ifndef TRANSFER_ENGINE_REGS_SVH
`define TRANSFER_ENGINE_REGS_SVH

// ==========================================
// Register port offsets
`define ENABLE_ADDR 16'hfef1
`define VECTOR_ADDR 16'hfef3
`define STATUS_ADDR 16'hfef4
`define MASK_ADDR 16'hfef5
`define STATE_ADDR 16'hfef6

// ==========================================
// Register information in RAM
`define INFO_BASE 24'h00_ec00
`define INFO_LAST 3'h5
`define INFO_STRIDE 24'h00_000c
`define STEP_BYTE 24'h00_0001
`define STEP_WORD 24'h00_0002

// ==========================================
// Field positions
`define SRC_MODE_BITS 7:6
`define DST_MODE_BITS 5:4
`define XFER_MODE_BITS 3:2
`define AREA_SIDE_BIT 1
`define UNIT_SIZE_BIT 0
`define CHAIN_BIT 7
`define CPU_IRQ_SEL_BIT 6
`define SW_ENABLE_BIT 7
`define SW_VECTOR_BITS 6:0
`define CH0_ENABLE_BIT 4
`define ST_FWD_BIT 0
`define ST_SW_BIT 1
`define ST_ERR_BIT 2

// ==========================================
// Reset values
`define ENABLE_RST 8'h00
`define VECTOR_RST 8'h00
`define EVENT_RST 3'h0

`endif

// >>> logic/transfer_engine_pkg.sv
// Types of the transfer engine's sequencer, mode field and memory port
// Assumes nothing beyond a SystemVerilog compiler
package transfer_engine_pkg;
    // Sequencer states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_READ = 3'h3,
        ST_WRITE = 3'h2,
        ST_UPDATE = 3'h6,
        ST_BACK = 3'h7,
        ST_DONE = 3'h5
    } state_t;
    // Transfer mode field encodings
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_REPEAT = 2'h1,
        MODE_BLOCK = 2'h2,
        MODE_BAD = 2'h3
    } mode_t;
    // Unit size on the memory port
    typedef enum logic {
        SIZE_BYTE = 1'b0,
        SIZE_WORD = 1'b1
    } unit_size_t;
endpackage

// >>> logic/transfer_engine.sv
// Transfer engine: activation, register information fetch, unit move, address update, write-back
// Assumes a no-wait memory port whose read data stand in the cycle after the read strobe
`include "transfer_engine_regs.svh"
module transfer_engine #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic [15:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    input wire logic SERIAL_IRQ_IN,
    output logic CPU_IRQ_OUT,
    output logic [ADDR_W-1:0] MEM_ADDR_OUT,
    output logic MEM_RD_OUT,
    output logic MEM_WR_OUT,
    output transfer_engine_pkg::unit_size_t MEM_SIZE_OUT,
    output logic [DATA_W-1:0] MEM_WDATA_OUT,
    input wire logic [DATA_W-1:0] MEM_RDATA_IN
);
    import transfer_engine_pkg::*;

    // The record layout fixes both widths
    if (ADDR_W != 24 || DATA_W != 16) begin : g_check
        $error("transfer_engine needs 24-bit addresses and 16-bit data");
    end

    state_t state_q;
    mode_t mode;
    unit_size_t size_q;
    logic [1:0] ph_q;
    logic [2:0] idx_q;
    logic [23:0] info_q, sar_q, dar_q, addr_q, sar_n, dar_n, span;
    logic [7:0] mra_q, mrb_q, enable_q, vector_q, rdata_q;
    logic [15:0] cra_q, crb_q, cra_n, crb_n, data_q, wdata_q, info_word;
    logic [2:0] status_q, mask_q, ev_set;
    logic rd_q, wr_q, irq_q, irq_d_q, hw_pend_q, from_hw_q, fwd_q, done_q;
    logic more_n, done_n, in_done, bad, chain_go;

    // ==========================================
    // Pointer arithmetic

    // Step a pointer by its two-bit mode and the unit size
    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic [1:0] m, input logic s);
        logic [23:0] st;
        st = s ? `STEP_WORD : `STEP_BYTE;
        if (!m[1]) begin
            step_addr = a;
        end else if (m[0]) begin
            step_addr = a - st;
        end else begin
            step_addr = a + st;
        end
    endfunction

    // Undo one area's worth of steps
    function automatic logic [23:0] rewind(input logic [23:0] a, input logic [1:0] m, input logic [23:0] sp);
        if (!m[1]) begin
            rewind = a;
        end else if (m[0]) begin
            rewind = a + sp;
        end else begin
            rewind = a - sp;
        end
    endfunction

    assign mode = mode_t'(mra_q[`XFER_MODE_BITS]);
    assign bad = (mode == MODE_BAD);
    assign span = mra_q[`UNIT_SIZE_BIT] ? {15'h0000, cra_q[15:8], 1'b0} : {16'h0000, cra_q[15:8]};

    // Next pointers and counts after one unit
    always_comb begin
        sar_n = step_addr(sar_q, mra_q[`SRC_MODE_BITS], mra_q[`UNIT_SIZE_BIT]);
        dar_n = step_addr(dar_q, mra_q[`DST_MODE_BITS], mra_q[`UNIT_SIZE_BIT]);
        cra_n = cra_q - 16'h0001;
        crb_n = crb_q;
        more_n = 1'b0;
        done_n = 1'b0;
        unique case (mode)
            MODE_NORMAL: begin
                done_n = (cra_q == 16'h0001);
            end
            MODE_REPEAT, MODE_BLOCK: begin
                cra_n = {cra_q[15:8], cra_q[7:0] - 8'h01};
                if (cra_q[7:0] == 8'h01) begin
                    cra_n = {cra_q[15:8], cra_q[15:8]};
                    if (mra_q[`AREA_SIDE_BIT]) begin
                        sar_n = rewind(sar_n, mra_q[`SRC_MODE_BITS], span);
                    end else begin
                        dar_n = rewind(dar_n, mra_q[`DST_MODE_BITS], span);
                    end
                    if (mode == MODE_BLOCK) begin
                        crb_n = crb_q - 16'h0001;
                        done_n = (crb_q == 16'h0001);
                    end
                end else begin
                    more_n = (mode == MODE_BLOCK);
                end
            end
            default: begin
                done_n = 1'b0;
            end
        endcase
    end

    // Record word for write-back
    always_comb begin
        unique case (idx_q)
            3'h0: info_word = {mra_q, sar_q[23:16]};
            3'h1: info_word = sar_q[15:0];
            3'h2: info_word = {mrb_q, dar_q[23:16]};
            3'h3: info_word = dar_q[15:0];
            3'h4: info_word = cra_q;
            default: info_word = crb_q;
        endcase
    end

    // ==========================================
    // Sequencer and memory port

    // Fetch, move, update and write back one record per pass
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            state_q <= ST_IDLE;
            ph_q <= 2'h0;
            idx_q <= 3'h0;
            info_q <= `INFO_BASE;
            {mra_q, mrb_q} <= 16'h0000;
            {sar_q, dar_q} <= 48'h0000_0000_0000;
            {cra_q, crb_q} <= 32'h0000_0000;
            data_q <= 16'h0000;
            {from_hw_q, fwd_q, done_q, rd_q, wr_q} <= 5'h00;
            addr_q <= 24'h00_0000;
            wdata_q <= 16'h0000;
            size_q <= SIZE_BYTE;
        end else begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (hw_pend_q || vector_q[`SW_ENABLE_BIT]) begin
                        state_q <= ST_FETCH;
                        from_hw_q <= hw_pend_q;
                        fwd_q <= 1'b0;
                        done_q <= 1'b0;
                        // Software picks a 16-byte slot above the base
                        info_q <= hw_pend_q ? `INFO_BASE :
                            `INFO_BASE + {13'h0000, vector_q[`SW_VECTOR_BITS], 4'h0};
                    end
                end
                ST_FETCH: begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        rd_q <= 1'b1;
                        addr_q <= info_q + {20'h0_0000, idx_q, 1'b0};
                        size_q <= SIZE_WORD;
                    end else if (ph_q == 2'h2) begin
                        ph_q <= 2'h0;
                        idx_q <= idx_q + 3'h1;
                        unique case (idx_q)
                            3'h0: {mra_q, sar_q[23:16]} <= MEM_RDATA_IN;
                            3'h1: sar_q[15:0] <= MEM_RDATA_IN;
                            3'h2: {mrb_q, dar_q[23:16]} <= MEM_RDATA_IN;
                            3'h3: dar_q[15:0] <= MEM_RDATA_IN;
                            3'h4: cra_q <= MEM_RDATA_IN;
                            default: crb_q <= MEM_RDATA_IN;
                        endcase
                        if (idx_q == `INFO_LAST) begin
                            idx_q <= 3'h0;
                            state_q <= bad ? ST_DONE : ST_READ;
                        end
                    end
                end
                ST_READ: begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        rd_q <= 1'b1;
                        addr_q <= sar_q;
                        size_q <= unit_size_t'(mra_q[`UNIT_SIZE_BIT]);
                    end else if (ph_q == 2'h2) begin
                        ph_q <= 2'h0;
                        data_q <= MEM_RDATA_IN;
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        wr_q <= 1'b1;
                        addr_q <= dar_q;
                        wdata_q <= data_q;
                    end else begin
                        ph_q <= 2'h0;
                        state_q <= ST_UPDATE;
                    end
                end
                ST_UPDATE: begin
                    sar_q <= sar_n;
                    dar_q <= dar_n;
                    cra_q <= cra_n;
                    crb_q <= crb_n;
                    done_q <= done_n;
                    fwd_q <= ~more_n & (mrb_q[`CPU_IRQ_SEL_BIT] | done_n);
                    state_q <= more_n ? ST_READ : ST_BACK;
                end
                ST_BACK: begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        wr_q <= 1'b1;
                        addr_q <= info_q + {20'h0_0000, idx_q, 1'b0};
                        wdata_q <= info_word;
                        size_q <= SIZE_WORD;
                    end else begin
                        ph_q <= 2'h0;
                        idx_q <= idx_q + 3'h1;
                        if (idx_q == `INFO_LAST) begin
                            idx_q <= 3'h0;
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    if (chain_go) begin
                        info_q <= info_q + `INFO_STRIDE;
                        fwd_q <= 1'b0;
                        done_q <= 1'b0;
                        state_q <= ST_FETCH;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign MEM_ADDR_OUT = addr_q;
    assign MEM_RD_OUT = rd_q;
    assign MEM_WR_OUT = wr_q;
    assign MEM_SIZE_OUT = size_q;
    assign MEM_WDATA_OUT = wdata_q;

    // ==========================================
    // Activation and events

    // Pass end events; chaining goes on only for a legal record
    assign in_done = (state_q == ST_DONE);
    assign chain_go = mrb_q[`CHAIN_BIT] & ~bad;
    assign ev_set[`ST_FWD_BIT] = in_done & from_hw_q & fwd_q;
    assign ev_set[`ST_SW_BIT] = in_done & ~from_hw_q & ~chain_go;
    assign ev_set[`ST_ERR_BIT] = in_done & bad;

    // Rising edge of the serial channel 0 request, gated per source
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            irq_q <= 1'b0;
            hw_pend_q <= 1'b0;
        end else begin
            irq_q <= SERIAL_IRQ_IN;
            hw_pend_q <= (SERIAL_IRQ_IN & ~irq_q & enable_q[`CH0_ENABLE_BIT]) |
                (hw_pend_q & (state_q != ST_IDLE));
        end
    end

    // ==========================================
    // Register port

    // Enable and vector registers; a software write beats a hardware clear
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            enable_q <= `ENABLE_RST;
            vector_q <= `VECTOR_RST;
        end else begin
            if (REG_WR_IN && REG_ADDR_IN == `ENABLE_ADDR) begin
                enable_q <= REG_WDATA_IN;
            end else if (in_done && from_hw_q && done_q) begin
                enable_q[`CH0_ENABLE_BIT] <= 1'b0;
            end
            if (REG_WR_IN && REG_ADDR_IN == `VECTOR_ADDR) begin
                vector_q <= REG_WDATA_IN;
            end else if (ev_set[`ST_SW_BIT]) begin
                vector_q[`SW_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // Sticky status, write one to clear, set wins; mask gates the interrupt
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            status_q <= `EVENT_RST;
            mask_q <= `EVENT_RST;
            irq_d_q <= 1'b0;
        end else begin
            status_q <= (status_q & ~((REG_WR_IN && REG_ADDR_IN == `STATUS_ADDR) ? REG_WDATA_IN[2:0] : 3'h0))
                | ev_set;
            if (REG_WR_IN && REG_ADDR_IN == `MASK_ADDR) begin
                mask_q <= REG_WDATA_IN[2:0];
            end
            irq_d_q <= |(status_q & mask_q);
        end
    end

    // Read data in the cycle after the strobe only; unmapped reads give zero
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= 8'h00;
            if (REG_RD_IN) begin
                unique case (REG_ADDR_IN)
                    `ENABLE_ADDR: rdata_q <= enable_q;
                    `VECTOR_ADDR: rdata_q <= vector_q;
                    `STATUS_ADDR: rdata_q <= {5'h00, status_q};
                    `MASK_ADDR: rdata_q <= {5'h00, mask_q};
                    `STATE_ADDR: rdata_q <= {5'h00, state_q};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign CPU_IRQ_OUT = irq_d_q;

    // ==========================================
    // Checks

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_hw_start;
        state_q == ST_IDLE && hw_pend_q;
    endsequence
    sequence s_unit_read;
        state_q == ST_READ && ph_q == 2'h0;
    endsequence

    property p_fetch_order;
        s_hw_start |=> ##1 (MEM_RD_OUT && MEM_ADDR_OUT == `INFO_BASE) ##3
            (MEM_RD_OUT && MEM_ADDR_OUT == `INFO_BASE + `STEP_WORD);
    endproperty
    a_fetch_order: assert property (p_fetch_order) else $error("record fetch order wrong");

    property p_move;
        s_unit_read |=> (MEM_RD_OUT && MEM_ADDR_OUT == $past(sar_q)) ##3
            (MEM_WR_OUT && MEM_ADDR_OUT == $past(dar_q, 4) && MEM_WDATA_OUT == $past(MEM_RDATA_IN, 2));
    endproperty
    a_move: assert property (p_move) else $error("unit not moved source to destination");

    property p_src_fixed;
        state_q == ST_UPDATE && mode == MODE_NORMAL && !mra_q[7] |=> sar_q == $past(sar_q);
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("fixed source pointer moved");

    property p_dst_step;
        state_q == ST_UPDATE && mode == MODE_NORMAL && mra_q[`DST_MODE_BITS] == 2'h2 |=>
            dar_q == $past(dar_q) + ($past(mra_q[`UNIT_SIZE_BIT]) ? `STEP_WORD : `STEP_BYTE);
    endproperty
    a_dst_step: assert property (p_dst_step) else $error("destination step wrong");

    property p_count;
        state_q == ST_UPDATE && mode == MODE_NORMAL |=> cra_q == $past(cra_q) - 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("count A not decremented");

    property p_bad_mode;
        state_q == ST_READ |-> mode != MODE_BAD;
    endproperty
    a_bad_mode: assert property (p_bad_mode) else $error("refused mode ran a transfer");

    property p_gate;
        !enable_q[`CH0_ENABLE_BIT] && !hw_pend_q |=> !hw_pend_q;
    endproperty
    a_gate: assert property (p_gate) else $error("disabled source activated");

    property p_forward;
        state_q == ST_UPDATE && from_hw_q && !more_n && (mrb_q[`CPU_IRQ_SEL_BIT] || done_n) |->
            ##14 status_q[`ST_FWD_BIT];
    endproperty
    a_forward: assert property (p_forward) else $error("interrupt not forwarded");

    property p_chain;
        in_done && mrb_q[`CHAIN_BIT] && !bad |=> state_q == ST_FETCH;
    endproperty
    a_chain: assert property (p_chain) else $error("chain not followed");
endmodule

// >>> dv/transfer_memory_model.sv
// Far-side model of the transfer engine: on-chip RAM with the serial channel data register
// Assumes a no-wait memory port clocked by the engine clock, big-endian words
module transfer_memory_model (
    input wire logic clk_in,
    input wire logic [23:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic size_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [15:0] a;
    int rd_count = 0;
    assign a = addr_in[15:0];
    initial rdata_out = 16'h0000;
    // ==========================================
    // Read data stand only in the cycle after the strobe, then toggle so stale data never match
    always @(posedge clk_in) begin
        if (rd_in) begin
            rdata_out <= size_in ? {mem[a], mem[a + 16'h0001]} : {~rdata_out[15:8], mem[a]};
            rd_count <= rd_count + 1;
        end else begin
            rdata_out <= ~rdata_out;
        end
    end
    // Writes land in RAM; 16'hffde stands for the serial channel data register
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem[a] <= size_in ? wdata_in[15:8] : wdata_in[7:0];
            if (size_in) begin
                mem[a + 16'h0001] <= wdata_in[7:0];
            end
        end
    end
endmodule

// >>> dv/transfer_engine_tb.sv
// Self-checking bench of the transfer engine: register port, hardware and software activation
// Assumes the memory model in dv/ and the engine's register header on the include path
`include "transfer_engine_regs.svh"
module transfer_engine_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic irq_line = 1'b0;
    logic [7:0] rdata;
    logic cpu_irq;
    logic [23:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic mem_size;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    int errors = 0;
    int checks_done = 0;
    logic [7:0] tx [4] = '{8'ha0, 8'h00, 8'h01, 8'h23};
    logic [1:0] codes [3] = '{2'b00, 2'b10, 2'b11};
    always #4 clk_sys = ~clk_sys;
    transfer_engine dut (.CLK_SYS_IN(clk_sys), .RESET_IN(reset), .REG_ADDR_IN(reg_addr),
        .REG_WDATA_IN(reg_wdata), .REG_WR_IN(wr_stb), .REG_RD_IN(rd_stb), .REG_RDATA_OUT(rdata),
        .SERIAL_IRQ_IN(irq_line), .CPU_IRQ_OUT(cpu_irq), .MEM_ADDR_OUT(mem_addr), .MEM_RD_OUT(mem_rd),
        .MEM_WR_OUT(mem_wr), .MEM_SIZE_OUT(mem_size), .MEM_WDATA_OUT(mem_wdata), .MEM_RDATA_IN(mem_rdata));
    transfer_memory_model mem_model (.clk_in(clk_sys), .addr_in(mem_addr), .rd_in(mem_rd), .wr_in(mem_wr),
        .size_in(mem_size), .wdata_in(mem_wdata), .rdata_out(mem_rdata));
    // ==========================================
    // Reporting and comparison
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ==========================================
    // Register port cycles
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        chk({16'h0000, d}, {16'h0000, exp});
    endtask
    // Polls the state code until the engine has left idle and come back, bounded
    task automatic wait_idle();
        logic [7:0] s;
        bit busy = 1'b0;
        for (int n = 0; n < 200; n++) begin
            reg_rd(`STATE_ADDR, s);
            if (s !== 8'h00) busy = 1'b1;
            else if (busy) return;
        end
        errors++;
        stop_test();
    endtask
    // ==========================================
    // Memory helpers and expectations
    function automatic logic [23:0] peek(input logic [15:0] a, input int n);
        logic [23:0] v = 24'h00_0000;
        for (int i = 0; i < n; i++) v = {v[15:0], mem_model.mem[a + i[15:0]]};
        return v;
    endfunction
    function automatic logic [23:0] step(input logic [23:0] p, input logic [1:0] m, input logic sz);
        logic [23:0] s;
        s = sz ? 24'h00_0002 : 24'h00_0001;
        if (!m[1]) return p;
        return m[0] ? p - s : p + s;
    endfunction
    task automatic put_rec(input logic [15:0] r, input logic [7:0] mode_register_a, input logic [7:0] mode_register_b,
                           input logic [15:0] src, input logic [15:0] dst, input logic [15:0] count_register_a);
        logic [7:0] b [12];
        b = '{mode_register_a, 8'h00, src[15:8], src[7:0], mode_register_b, 8'h00, dst[15:8], dst[7:0], count_register_a[15:8], count_register_a[7:0], 8'h00, 8'h02};
        for (int i = 0; i < 12; i++) mem_model.mem[r + i[15:0]] = b[i];
    endtask
    task automatic sw_run(input logic [6:0] v, input logic [7:0] mode_register_a, input logic [15:0] count_register_a);
        put_rec({8'hec, v[3:0], 4'h0}, mode_register_a, 8'h00, 16'he204, 16'he304, count_register_a);
        mem_model.mem[16'he304] = 8'h00;
        mem_model.mem[16'he305] = 8'h00;
        reg_wr(`VECTOR_ADDR, {1'b1, v});
        wait_idle();
    endtask
    task automatic pulse();
        @(posedge clk_sys);
        irq_line <= 1'b1;
        wait_idle();
        @(posedge clk_sys);
        irq_line <= 1'b0;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic [15:0] r;
        logic [7:0] st;
        int n;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        rd_chk(`ENABLE_ADDR, `ENABLE_RST);
        rd_chk(`VECTOR_ADDR, `VECTOR_RST);
        rd_chk(`STATE_ADDR, 8'h00);
        reg_wr(16'h1234, 8'hff);
        rd_chk(16'h1234, 8'h00);
        $display("test reset done");
        // Serial channel activation, normal mode, byte, source counting up, two transfers
        for (int i = 0; i < 4; i++) mem_model.mem[16'he100 + i[15:0]] = tx[i];
        put_rec(16'hec00, 8'h80, 8'h00, 16'he100, 16'hffde, 16'h0002);
        reg_wr(`MASK_ADDR, 8'h07);
        reg_wr(`ENABLE_ADDR, 8'h10);
        for (int k = 0; k < 2; k++) begin
            pulse();
            chk(peek(16'hffde, 1), {16'h0000, tx[k]});
            chk(peek(16'hec01, 3), 24'h00_e101 + {23'h0, k[0]});
            chk(peek(16'hec08, 2), {23'h0, ~k[0]});
            rd_chk(`STATUS_ADDR, {7'h00, k[0]});
            chk({23'h0, cpu_irq}, {23'h0, k[0]});
        end
        rd_chk(`ENABLE_ADDR, 8'h00);
        reg_wr(`STATUS_ADDR, 8'h01);
        rd_chk(`STATUS_ADDR, 8'h00);
        chk({23'h0, cpu_irq}, 24'h00_0000);
        // Interrupt select set forwards while the count is still non-zero; then masked
        mem_model.mem[16'hec04] = 8'h40;
        mem_model.mem[16'hec09] = 8'h05;
        reg_wr(`ENABLE_ADDR, 8'h10);
        pulse();
        rd_chk(`STATUS_ADDR, 8'h01);
        chk(peek(16'hffde, 1), {16'h0000, tx[2]});
        reg_wr(`MASK_ADDR, 8'h00);
        @(posedge clk_sys);
        #1 chk({23'h0, cpu_irq}, 24'h00_0000);
        reg_wr(`STATUS_ADDR, 8'h07);
        reg_wr(`MASK_ADDR, 8'h07);
        // A rise with channel 0 disabled is lost
        reg_wr(`ENABLE_ADDR, 8'h00);
        n = mem_model.rd_count;
        @(posedge clk_sys);
        irq_line <= 1'b1;
        repeat (20) @(posedge clk_sys);
        irq_line <= 1'b0;
        chk(mem_model.rd_count[23:0], n[23:0]);
        $display("test serial activation done");
        // Software activation over every pair of the fixed (00), up (10) and down (11) step modes, unit size alternating byte and word
        for (int i = 0; i < 9; i++) begin
            r = {8'hec, i[3:0] + 4'h1, 4'h0};
            mem_model.mem[16'he204] = 8'h5a + i[7:0];
            mem_model.mem[16'he205] = 8'hc3;
            sw_run(i[6:0] + 7'h01, {codes[i / 3], codes[i % 3], 3'b000, i[0]}, 16'h0003);
            chk(peek(16'he304, 2), {8'h00, 8'h5a + i[7:0], i[0] ? 8'hc3 : 8'h00});
            chk(peek(r + 16'h0001, 3), step(24'h00_e204, codes[i / 3], i[0]));
            chk(peek(r + 16'h0005, 3), step(24'h00_e304, codes[i % 3], i[0]));
            chk(peek(r + 16'h0008, 2), 24'h00_0002);
            rd_chk(`STATUS_ADDR, 8'h02);
            rd_chk(`VECTOR_ADDR, {1'b0, i[6:0] + 7'h01});
            reg_wr(`STATUS_ADDR, 8'h07);
        end
        $display("test step modes done");
        // Repeat mode, source area, counter not yet wrapped
        sw_run(7'h0a, 8'h86, 16'h0403);
        chk(peek(16'heca1, 3), 24'h00_e205);
        chk(peek(16'heca8, 2), 24'h00_0402);
        // Repeat mode, source area of two bytes wrapping: source rewound, counter reloaded
        sw_run(7'h0f, 8'h86, 16'h0201);
        chk(peek(16'hecf1, 3), 24'h00_e203);
        chk(peek(16'hecf8, 2), 24'h00_0202);
        // Block mode, destination area of one unit: area rewound, block count down
        sw_run(7'h0b, 8'h28, 16'h0101);
        chk(peek(16'he304, 1), {16'h0000, mem_model.mem[16'he204]});
        chk(peek(16'hecb5, 3), 24'h00_e304);
        chk(peek(16'hecb8, 4), 24'h01_0001);
        chk(peek(16'hecb8, 2), 24'h00_0101);
        reg_wr(`STATUS_ADDR, 8'h07);
        // Mode code 11 is refused: no unit moved, no write-back
        sw_run(7'h0c, 8'h2c, 16'h0003);
        reg_rd(`STATUS_ADDR, st);
        chk({23'h0, st[2]}, 24'h00_0001);
        chk(peek(16'he304, 1), 24'h00_0000);
        chk(peek(16'hecc5, 3), 24'h00_e304);
        // Chain: first record moves one byte, then the record 12 bytes above it runs in the same pass
        reg_wr(`STATUS_ADDR, 8'h07);
        mem_model.mem[16'he304] = 8'h00;
        mem_model.mem[16'he305] = 8'h00;
        put_rec(16'hecd0, 8'h80, 8'h80, 16'he204, 16'he304, 16'h0003);
        put_rec(16'hecdc, 8'h00, 8'h00, 16'he205, 16'he305, 16'h0003);
        reg_wr(`VECTOR_ADDR, 8'h8d);
        wait_idle();
        chk(peek(16'he304, 2), {8'h00, 8'h62, 8'hc3});
        chk(peek(16'hecd1, 3), 24'h00_e205);
        chk(peek(16'hece4, 2), 24'h00_0002);
        rd_chk(`STATUS_ADDR, 8'h02);
        reg_wr(`VECTOR_ADDR, 8'h00);
        $display("test transfer modes done");
        stop_test();
    end
endmodule
